// file: src/mdc_config_bank.sv
// Configuration register bank with lock, fault pin and overcurrent control
`timescale 1ns/1ps
`default_nettype none
module mdc_config_bank #(
  parameter int unsigned RETRY_SHORT_CYCLES = mdc_pkg::RETRY_SHORT_CYC,
  parameter int unsigned RETRY_LONG_CYCLES  = mdc_pkg::RETRY_LONG_CYC
) (
  input  wire logic        CLK,        // 25 MHz system clock
  input  wire logic        ARST_N,     // Asynchronous reset, low
  input  wire logic        CE,         // Clock enable, freezes all state but the reset synchroniser
  input  wire logic        SCLK,       // Serial clock pin
  input  wire logic        SCS_N,      // Serial chip select, low
  input  wire logic        SDI,        // Serial data in pin
  output logic             SDO_O,      // Serial data out level
  output logic             SDO_OE,     // Serial data out enable
  input  wire logic        OC_RAW,     // Overcurrent comparator
  input  wire logic        OTW_RAW,    // Overtemperature warning
  input  wire logic        PWM_IN,     // PWM input for cycle clear
  output logic             FAULT_N_O,  // Fault pin level, always low
  output logic             FAULT_N_OE, // Fault pin pulled low
  output logic             DRIVER_HIZ, // Output stage high impedance
  output logic             OC_ACTIVE,  // Overcurrent fault in force
  output mdc_pkg::mdc_cfg_s CFG        // Decoded configuration
);
  typedef struct packed {
    logic [7:0]       mode_reg;
    logic [7:0]       prot_reg;
    logic [7:0]       oc_reg;
    logic [7:0]       rect_reg;
    logic [7:0]       regu_reg;
    logic [2:0]       lock_val;
    logic             locked;
    logic [1:0]       oc_sync;
    logic [1:0]       otw_sync;
    logic [1:0]       pwm_sync;
    logic             pwm_prev;
    logic [5:0]       deg_cnt;
    logic [23:0]      retry_cnt;
    mdc_pkg::mdc_oc_e oc_state;
    logic             oc_flag;
    logic             spi_flt;
    logic             fault_drv;
    logic             hiz;
  } mdc_bank_st_s;

  localparam mdc_bank_st_s ST_RST = '{
    mode_reg: mdc_pkg::RST_MODE,
    prot_reg: mdc_pkg::RST_PROT,
    oc_reg:   mdc_pkg::RST_OC,
    rect_reg: mdc_pkg::RST_RECT,
    regu_reg: mdc_pkg::RST_REGU,
    oc_state: mdc_pkg::OC_IDLE,
    default:  '0
  };

  mdc_bank_st_s     s_reg;
  mdc_bank_st_s     s_next;
  logic [1:0]       rst_sync_reg;
  logic             rst_n;
  mdc_pkg::mdc_wr_s wr;
  logic             frame_err;
  logic [5:0]       rd_addr;
  logic [7:0]       rd_data;
  logic             sdo_bit;
  logic             sp_active;
  logic             wr_ok;
  logic             clr;
  logic             oc_event;
  logic             cbc_clear;
  logic [1:0]       resp;
  logic [23:0]      retry_last;

  // Deglitch length for a filter code
  function automatic logic [5:0] deg_cycles(input logic [1:0] code);
    logic [5:0] c;
    unique case (code)
      2'h0: c = mdc_pkg::DEG0_CYC;
      2'h1: c = mdc_pkg::DEG1_CYC;
      2'h2: c = mdc_pkg::DEG2_CYC;
      2'h3: c = mdc_pkg::DEG3_CYC;
    endcase
    return c;
  endfunction

  // Read value of a register; unmapped offsets read zero
  function automatic logic [7:0] rd_mux(input logic [5:0] a, input mdc_bank_st_s st);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      mdc_pkg::ADDR_LOCK: v = {5'h00, st.lock_val};
      mdc_pkg::ADDR_MODE: v = st.mode_reg;
      mdc_pkg::ADDR_PROT: v = st.prot_reg;
      mdc_pkg::ADDR_OC:   v = st.oc_reg;
      mdc_pkg::ADDR_RECT: v = st.rect_reg;
      mdc_pkg::ADDR_REGU: v = st.regu_reg;
      default:            v = 8'h00;
    endcase
    return v;
  endfunction

  // Reset released through two stages so all state leaves reset together
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  mdc_serial_port u_port (
    .clk       (CLK),
    .rst_n     (rst_n),
    .ce        (CE),
    .sclk      (SCLK),
    .cs_n      (SCS_N),
    .sdi       (SDI),
    .rd_data   (rd_data),
    .wr        (wr),
    .frame_err (frame_err),
    .rd_addr   (rd_addr),
    .sdo       (sdo_bit),
    .active    (sp_active)
  );

  assign rd_data = rd_mux(rd_addr, s_reg);

  // Write gating by the lock and the clear command pulse
  always_comb
  begin
    wr_ok = wr.valid && (!s_reg.locked || wr.addr == mdc_pkg::ADDR_LOCK);
    clr = wr_ok && wr.addr == mdc_pkg::ADDR_MODE && wr.data[mdc_pkg::CLR_BIT];
    resp = s_reg.oc_reg[mdc_pkg::RESP_LSB +: 2];
    cbc_clear = s_reg.oc_reg[mdc_pkg::CBC_BIT] && (s_reg.pwm_sync[1] != s_reg.pwm_prev);
    if (s_reg.oc_reg[mdc_pkg::RTRY_BIT])
      retry_last = 24'(RETRY_LONG_CYCLES - 1);
    else
      retry_last = 24'(RETRY_SHORT_CYCLES - 1);
  end

  // Next state of the whole bank
  always_comb
  begin
    s_next = s_reg;
    oc_event = 1'b0;
    s_next.oc_sync = {s_reg.oc_sync[0], OC_RAW};
    s_next.otw_sync = {s_reg.otw_sync[0], OTW_RAW};
    s_next.pwm_sync = {s_reg.pwm_sync[0], PWM_IN};
    s_next.pwm_prev = s_reg.pwm_sync[1];

    // Register writes; masks keep read-zero bits and the clear bit at zero
    if (wr_ok)
    begin
      unique case (wr.addr)
        mdc_pkg::ADDR_LOCK:
        begin
          s_next.lock_val = wr.data[2:0];
          if (wr.data[2:0] == mdc_pkg::LOCK_KEY)
            s_next.locked = 1'b1;
          else if (wr.data[2:0] == mdc_pkg::UNLOCK_KEY)
            s_next.locked = 1'b0;
        end
        mdc_pkg::ADDR_MODE: s_next.mode_reg = wr.data & mdc_pkg::WMASK_MODE;
        mdc_pkg::ADDR_PROT: s_next.prot_reg = wr.data & mdc_pkg::WMASK_PROT;
        mdc_pkg::ADDR_OC:   s_next.oc_reg = wr.data;
        mdc_pkg::ADDR_RECT: s_next.rect_reg = wr.data;
        mdc_pkg::ADDR_REGU: s_next.regu_reg = wr.data & mdc_pkg::WMASK_REGU;
        default:            s_next.lock_val = s_reg.lock_val;
      endcase
    end

    // Overcurrent must hold for the whole filter time before it counts
    if (s_reg.oc_sync[1])
    begin
      if (s_reg.deg_cnt + 6'h01 >= deg_cycles(s_reg.oc_reg[mdc_pkg::DEG_LSB +: 2]))
        oc_event = 1'b1;
      else
        s_next.deg_cnt = s_reg.deg_cnt + 6'h01;
    end
    else
      s_next.deg_cnt = 6'h00;

    // Response to an accepted overcurrent
    unique case (s_reg.oc_state)
      mdc_pkg::OC_IDLE:
      begin
        if (oc_event && resp == mdc_pkg::RESP_LATCH)
          s_next.oc_state = mdc_pkg::OC_LATCHED;
        else if (oc_event && resp == mdc_pkg::RESP_RETRY)
        begin
          s_next.oc_state = mdc_pkg::OC_RETRY;
          s_next.retry_cnt = 24'h000000;
        end
      end
      mdc_pkg::OC_LATCHED:
      begin
        if (clr || cbc_clear)
        begin
          s_next.oc_state = mdc_pkg::OC_IDLE;
          s_next.deg_cnt = 6'h00;
        end
      end
      mdc_pkg::OC_RETRY:
      begin
        if (cbc_clear || s_reg.retry_cnt >= retry_last)
        begin
          s_next.oc_state = mdc_pkg::OC_IDLE;
          s_next.deg_cnt = 6'h00;
        end
        else
          s_next.retry_cnt = s_reg.retry_cnt + 24'h000001;
      end
      default: s_next.oc_state = mdc_pkg::OC_IDLE;
    endcase

    // Sticky fault flags; a new event beats a clear in the same cycle
    s_next.oc_flag = (oc_event && resp != mdc_pkg::RESP_NONE) || (s_reg.oc_flag && !clr);
    s_next.spi_flt = frame_err || (s_reg.spi_flt && !clr);

    // Fault pin sources; overcurrent flag always, serial and warning faults each behind a reporting bit
    s_next.fault_drv = s_reg.oc_flag
      || (s_reg.spi_flt && !s_reg.prot_reg[mdc_pkg::SREP_BIT])
      || (s_reg.otw_sync[1] && s_reg.prot_reg[mdc_pkg::OREP_BIT]);

    // Output stage off by software or by an active overcurrent fault
    s_next.hiz = s_reg.oc_reg[mdc_pkg::DOFF_BIT] || s_reg.oc_state != mdc_pkg::OC_IDLE;
  end

  // Single state register, frozen while CE is low
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= ST_RST;
    else if (CE)
      s_reg <= s_next;
  end

  // Open drain only pulls low; push-pull drives both levels during a frame
  always_comb
  begin
    if (s_reg.mode_reg[mdc_pkg::SDO_BIT])
    begin
      SDO_O = sdo_bit;
      SDO_OE = sp_active;
    end
    else
    begin
      SDO_O = 1'b0;
      SDO_OE = sp_active && !sdo_bit;
    end
  end

  // Fault pin is open drain and active low
  assign FAULT_N_O = 1'b0;
  assign FAULT_N_OE = s_reg.fault_drv;
  assign DRIVER_HIZ = s_reg.hiz;
  assign OC_ACTIVE = s_reg.oc_state != mdc_pkg::OC_IDLE;

  // Field decode for the power and analog sections
  assign CFG.serial_out_drive_select = s_reg.mode_reg[mdc_pkg::SDO_BIT];
  assign CFG.slew_rate = s_reg.mode_reg[mdc_pkg::SLEW_LSB +: 2];
  assign CFG.input_mode = s_reg.mode_reg[mdc_pkg::INMD_LSB +: 2];
  assign CFG.full_duty_freq = s_reg.prot_reg[mdc_pkg::FREQ_BIT];
  assign CFG.overvoltage_level_select = s_reg.prot_reg[mdc_pkg::OVSEL_BIT];
  assign CFG.overvoltage_enable = s_reg.prot_reg[mdc_pkg::OVEN_BIT];
  assign CFG.overcurrent_threshold = s_reg.oc_reg[mdc_pkg::LVL_BIT];
  assign CFG.limit_recirculation_select = s_reg.rect_reg[mdc_pkg::RECIR_BIT];
  assign CFG.sync_rectify_enable = s_reg.rect_reg[mdc_pkg::ASR_BIT];
  assign CFG.async_rectify_enable = s_reg.rect_reg[mdc_pkg::AAR_BIT];
  assign CFG.sense_amp_gain = s_reg.rect_reg[mdc_pkg::GAIN_LSB +: 2];
  assign CFG.regulator_sequencing_off = s_reg.regu_reg[mdc_pkg::SEQ_BIT];
  assign CFG.regulator_current_limit = s_reg.regu_reg[mdc_pkg::BCL_BIT];
  assign CFG.regulator_voltage = s_reg.regu_reg[mdc_pkg::VSEL_LSB +: 2];
  assign CFG.regulator_disable = s_reg.regu_reg[mdc_pkg::BDIS_BIT];
endmodule
`default_nettype wire

// file: include/mdc_pkg.sv
// Constants and types for the motor driver configuration register bank
package mdc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;

  // Register offsets
  localparam logic [5:0] ADDR_LOCK = 6'h03;
  localparam logic [5:0] ADDR_MODE = 6'h04;
  localparam logic [5:0] ADDR_PROT = 6'h05;
  localparam logic [5:0] ADDR_OC   = 6'h06;
  localparam logic [5:0] ADDR_RECT = 6'h07;
  localparam logic [5:0] ADDR_REGU = 6'h08;

  // Reset values and writable masks
  localparam logic [7:0] RST_MODE   = 8'h60;
  localparam logic [7:0] RST_PROT   = 8'h46;
  localparam logic [7:0] RST_OC     = 8'h10;
  localparam logic [7:0] RST_RECT   = 8'h00;
  localparam logic [7:0] RST_REGU   = 8'h00;
  localparam logic [7:0] WMASK_MODE = 8'hfe;
  localparam logic [7:0] WMASK_PROT = 8'h7f;
  localparam logic [7:0] WMASK_REGU = 8'h3f;
  localparam logic [2:0] LOCK_KEY   = 3'h6;
  localparam logic [2:0] UNLOCK_KEY = 3'h3;

  // Field positions
  localparam int SDO_BIT   = 5;
  localparam int SLEW_LSB  = 3;
  localparam int INMD_LSB  = 1;
  localparam int CLR_BIT   = 0;
  localparam int FREQ_BIT  = 4;
  localparam int OVSEL_BIT = 3;
  localparam int OVEN_BIT  = 2;
  localparam int SREP_BIT  = 1;
  localparam int OREP_BIT  = 0;
  localparam int DOFF_BIT  = 7;
  localparam int CBC_BIT   = 6;
  localparam int DEG_LSB   = 4;
  localparam int RTRY_BIT  = 3;
  localparam int LVL_BIT   = 2;
  localparam int RESP_LSB  = 0;
  localparam int RECIR_BIT = 6;
  localparam int AAR_BIT   = 3;
  localparam int ASR_BIT   = 2;
  localparam int GAIN_LSB  = 0;
  localparam int SEQ_BIT   = 4;
  localparam int BCL_BIT   = 3;
  localparam int VSEL_LSB  = 1;
  localparam int BDIS_BIT  = 0;

  // Serial frame layout
  localparam logic [4:0] FRAME_BITS = 5'd16;
  localparam logic [4:0] ADDR_DONE  = 5'd7;
  localparam int RW_BIT   = 15;
  localparam int ADDR_POS = 9;

  // Overcurrent deglitch times, least times rounded up
  localparam int unsigned DEG0_NS  = 200;
  localparam int unsigned DEG1_NS  = 600;
  localparam int unsigned DEG2_NS  = 1250;
  localparam int unsigned DEG3_NS  = 1600;
  localparam logic [5:0] DEG0_CYC = 6'((DEG0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] DEG1_CYC = 6'((DEG1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] DEG2_CYC = 6'((DEG2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] DEG3_CYC = 6'((DEG3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Overcurrent retry waits
  localparam int unsigned RETRY_SHORT_MS  = 5;
  localparam int unsigned RETRY_LONG_MS   = 500;
  localparam int unsigned RETRY_SHORT_CYC = RETRY_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RETRY_LONG_CYC  = RETRY_LONG_MS * 1000000 / CLK_PERIOD_NS;

  // Overcurrent response codes
  localparam logic [1:0] RESP_LATCH  = 2'h0;
  localparam logic [1:0] RESP_RETRY  = 2'h1;
  localparam logic [1:0] RESP_REPORT = 2'h2;
  localparam logic [1:0] RESP_NONE   = 2'h3;

  typedef enum logic [1:0] {OC_IDLE, OC_LATCHED, OC_RETRY} mdc_oc_e;

  // Accepted serial write
  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic [7:0] data;
  } mdc_wr_s;

  // Decoded configuration towards the analog side
  typedef struct packed {
    logic       serial_out_drive_select;
    logic [1:0] slew_rate;
    logic [1:0] input_mode;
    logic       full_duty_freq;
    logic       overvoltage_level_select;
    logic       overvoltage_enable;
    logic       overcurrent_threshold;
    logic       limit_recirculation_select;
    logic       sync_rectify_enable;
    logic       async_rectify_enable;
    logic [1:0] sense_amp_gain;
    logic       regulator_sequencing_off;
    logic       regulator_current_limit;
    logic [1:0] regulator_voltage;
    logic       regulator_disable;
  } mdc_cfg_s;
endpackage

// file: src/mdc_serial_port.sv
// Sixteen-bit serial slave that turns pin frames into register accesses
`timescale 1ns/1ps
`default_nettype none
module mdc_serial_port (
  input  wire logic           clk,       // System clock
  input  wire logic           rst_n,     // Synchronised reset
  input  wire logic           ce,        // Clock enable
  input  wire logic           sclk,      // Serial clock pin
  input  wire logic           cs_n,      // Chip select pin
  input  wire logic           sdi,       // Serial data in pin
  input  wire logic [7:0]     rd_data,   // Read data for rd_addr
  output mdc_pkg::mdc_wr_s    wr,        // Write pulse
  output logic                frame_err, // Bad frame pulse
  output logic [5:0]          rd_addr,   // Address being read
  output logic                sdo,       // Serial data out bit
  output logic                active     // Frame in progress
);
  typedef struct packed {
    logic [1:0]       cs_sync;
    logic [1:0]       sclk_sync;
    logic [1:0]       sdi_sync;
    logic             sclk_prev;
    logic             cs_prev;
    logic [4:0]       cnt;
    logic [15:0]      rx;
    logic [7:0]       tx;
    logic             sdo;
    logic             err;
    mdc_pkg::mdc_wr_s wr;
  } mdc_sp_st_s;

  mdc_sp_st_s s_reg;
  mdc_sp_st_s s_next;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;

  // Pins pass two stages; edges look at the second only
  always_comb
  begin
    s_next = s_reg;
    s_next.cs_sync = {s_reg.cs_sync[0], cs_n};
    s_next.sclk_sync = {s_reg.sclk_sync[0], sclk};
    s_next.sdi_sync = {s_reg.sdi_sync[0], sdi};
    s_next.sclk_prev = s_reg.sclk_sync[1];
    s_next.cs_prev = s_reg.cs_sync[1];
    s_next.wr.valid = 1'b0;
    s_next.err = 1'b0;
    sclk_rise = s_reg.sclk_sync[1] & ~s_reg.sclk_prev;
    sclk_fall = ~s_reg.sclk_sync[1] & s_reg.sclk_prev;
    cs_rise = s_reg.cs_sync[1] & ~s_reg.cs_prev;
    if (cs_rise)
    begin
      // Only a whole frame counts; short or long ones flag a fault
      if (s_reg.cnt != mdc_pkg::FRAME_BITS)
        s_next.err = 1'b1;
      else if (!s_reg.rx[mdc_pkg::RW_BIT])
      begin
        s_next.wr.valid = 1'b1;
        s_next.wr.addr = s_reg.rx[mdc_pkg::ADDR_POS +: 6];
        s_next.wr.data = s_reg.rx[7:0];
      end
      s_next.cnt = '0;
      s_next.sdo = 1'b0;
    end
    else if (!s_reg.cs_sync[1])
    begin
      // Sample on falling edge, shift out on rising edge
      if (sclk_fall)
      begin
        s_next.rx = {s_reg.rx[14:0], s_reg.sdi_sync[1]};
        if (s_reg.cnt != 5'h1f)
          s_next.cnt = s_reg.cnt + 5'h01;
        if (s_reg.cnt == mdc_pkg::ADDR_DONE)
          s_next.tx = rd_data;
      end
      if (sclk_rise)
      begin
        if (s_reg.cnt > mdc_pkg::ADDR_DONE)
        begin
          s_next.sdo = s_reg.tx[7];
          s_next.tx = {s_reg.tx[6:0], 1'b0};
        end
        else
          s_next.sdo = 1'b0;
      end
    end
  end

  // Single state register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '{cs_sync: 2'h3, cs_prev: 1'b1, default: '0};
    else if (ce)
      s_reg <= s_next;
  end

  assign wr = s_reg.wr;
  assign frame_err = s_reg.err;
  assign rd_addr = s_reg.rx[5:0];
  assign sdo = s_reg.sdo;
  assign active = ~s_reg.cs_sync[1];
endmodule
`default_nettype wire

// file: tb/mdc_checker.sv
// Concurrent checks on the ports of the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module mdc_checker #(
  parameter int unsigned RETRY_SHORT_CYCLES = 20,
  parameter int unsigned RETRY_LONG_CYCLES  = 50
) (
  input wire logic              CLK,        // System clock
  input wire logic              ARST_N,     // Reset, low
  input wire logic              CE,         // Clock enable, high runs
  input wire logic              SCS_N,      // Chip select
  input wire logic              SDO_O,      // Data out level
  input wire logic              SDO_OE,     // Data out enable
  input wire logic              OC_RAW,     // Overcurrent input
  input wire logic              OTW_RAW,    // Warning input
  input wire logic              FAULT_N_O,  // Fault pin level
  input wire logic              FAULT_N_OE, // Fault pin enable
  input wire logic              DRIVER_HIZ, // Output stage off
  input wire logic              OC_ACTIVE,  // Overcurrent state
  input wire mdc_pkg::mdc_cfg_s CFG         // Decoded fields
);
  // One clock domain; nothing is judged while reset holds
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  a_fault_pin_low : assert property (FAULT_N_O == 1'b0)
    else $error("fault pin level not low");
  a_sdo_idle_off : assert property (SCS_N [*5] |-> !SDO_OE)
    else $error("data out driven while deselected");
  a_sdo_pp_drive : assert property ((CFG.serial_out_drive_select && !SCS_N && CE) [*5]
    |-> SDO_OE)
    else $error("push-pull data out not driven");
  a_sdo_od_low : assert property (!CFG.serial_out_drive_select && SDO_OE |-> !SDO_O)
    else $error("open drain output driven high");
  // Shortest filter code needs five synchronised samples of the comparator
  a_oc_filter_time : assert property ($rose(OC_ACTIVE) |->
    $past(OC_RAW, 3) && $past(OC_RAW, 4) && $past(OC_RAW, 5)
    && $past(OC_RAW, 6) && $past(OC_RAW, 7))
    else $error("overcurrent accepted before filter time");
  a_hiz_after_frame : assert property ($changed(DRIVER_HIZ) |->
    $past(SCS_N, 4) && $past(SCS_N, 5))
    else $error("stage off changed outside a write");
  a_cfg_after_frame : assert property ($changed(CFG) |->
    $past(SCS_N, 3) && $past(SCS_N, 4))
    else $error("configuration changed outside a write");
  a_fault_clear_frame : assert property ($fell(FAULT_N_OE) |->
    $past(SCS_N, 4) || !$past(OTW_RAW, 3))
    else $error("fault pin released without a clear");
endmodule

bind mdc_config_bank mdc_checker #(
  .RETRY_SHORT_CYCLES(RETRY_SHORT_CYCLES),
  .RETRY_LONG_CYCLES (RETRY_LONG_CYCLES)
) u_chk (
  .CLK(CLK), .ARST_N(ARST_N), .CE(CE), .SCS_N(SCS_N), .SDO_O(SDO_O),
  .SDO_OE(SDO_OE), .OC_RAW(OC_RAW), .OTW_RAW(OTW_RAW),
  .FAULT_N_O(FAULT_N_O), .FAULT_N_OE(FAULT_N_OE),
  .DRIVER_HIZ(DRIVER_HIZ), .OC_ACTIVE(OC_ACTIVE), .CFG(CFG)
);
`default_nettype wire

// file: tb/mdc_host_model.sv
// Host microcontroller model driving the serial port of the bank
`timescale 1ns/1ps
`default_nettype none
module mdc_host_model (
  input  wire logic  clk,    // System clock
  input  wire logic  sdo_o,  // Device data level
  input  wire logic  sdo_oe, // Device drive enable
  output logic       sclk,   // Serial clock, low between frames
  output logic       scs_n,  // Chip select, low
  output logic       sdi,    // Serial data to device
  output logic       rdone,  // Read frame finished
  output logic [7:0] rdata   // Byte shifted in
);
  logic        sdo_w;
  logic [15:0] sh;
  // Pull-up: open drain ones and an idle line read high
  assign sdo_w = sdo_oe ? sdo_o : 1'b1;
  // Idle levels
  initial
  begin
    sclk = 1'b0;
    scs_n = 1'b1;
    sdi = 1'b0;
    rdone = 1'b0;
    rdata = 8'h00;
    sh = 16'h0000;
  end
  // MSB first; five clocks a half bit so the synchroniser keeps up
  task automatic xfer(input logic [15:0] f, input int nb);
    scs_n = 1'b0;
    repeat (5) @(negedge clk);
    for (int i = 0; i < nb; i++)
    begin
      sclk = 1'b1;
      sdi = f[15 - i];
      repeat (5) @(negedge clk);
      sclk = 1'b0;
      sh = {sh[14:0], sdo_w};
      repeat (5) @(negedge clk);
    end
    scs_n = 1'b1;
    sdi = ~sdi;
    rdata = sh[7:0];
    rdone = f[15] && nb == 16;
    @(negedge clk);
    rdone = 1'b0;
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the motor driver configuration registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) \
  begin fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb;
  logic              CLK, ARST_N, CE, OC_RAW, OTW_RAW, PWM_IN;
  logic              SCLK, SCS_N, SDI, SDO_O, SDO_OE, rdone;
  logic              FAULT_N_O, FAULT_N_OE, DRIVER_HIZ, OC_ACTIVE;
  mdc_pkg::mdc_cfg_s CFG;
  logic [7:0]        rdata, ev;
  logic [7:0]        expq [$];
  logic [7:0]        d [5];
  int                fail_count = 0;
  int                n_compared = 0;
  int                cycles = 0;
  // Read-zero and self-clearing bits drop out of read-back
  localparam logic [7:0] MSK [5] = '{8'hfe, 8'h7f, 8'hff, 8'hff, 8'h3f};
  localparam logic [7:0] RV [5] = '{8'h60, 8'h46, 8'h10, 8'h00, 8'h00};
  localparam logic [7:0] OCV [5] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h01};

  mdc_config_bank #(.RETRY_SHORT_CYCLES(20), .RETRY_LONG_CYCLES(50)) dut (
    .CLK(CLK), .ARST_N(ARST_N), .CE(CE), .SCLK(SCLK), .SCS_N(SCS_N),
    .SDI(SDI), .SDO_O(SDO_O), .SDO_OE(SDO_OE), .OC_RAW(OC_RAW),
    .OTW_RAW(OTW_RAW), .PWM_IN(PWM_IN), .FAULT_N_O(FAULT_N_O),
    .FAULT_N_OE(FAULT_N_OE), .DRIVER_HIZ(DRIVER_HIZ),
    .OC_ACTIVE(OC_ACTIVE), .CFG(CFG));
  mdc_host_model host (.clk(CLK), .sdo_o(SDO_O), .sdo_oe(SDO_OE),
    .sclk(SCLK), .scs_n(SCS_N), .sdi(SDI), .rdone(rdone), .rdata(rdata));

  // 25 MHz clock
  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // Ceiling on the run so a stuck frame cannot hang it
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      $display("[FAIL] run length exp under 60000 got %0d", cycles);
      fail_count++;
      results();
    end
  end
  // Each finished read is matched with the oldest note
  always @(posedge CLK)
    if (rdone === 1'b1)
    begin
      if (expq.size() == 0)
      begin
        $display("[FAIL] read note exp 1 got %0d", expq.size());
        fail_count++;
      end
      else
      begin
        ev = expq.pop_front();
        `CHK("read data", ev, rdata)
      end
    end

  function automatic mdc_pkg::mdc_cfg_s cfg_of(input logic [7:0] m, p, o, r, g);
    return {m[5], m[4:3], m[2:1], p[4], p[3], p[2], o[2], r[6], r[2], r[3],
      r[1:0], g[4], g[3], g[2:1], g[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask
  // Register index 0 is the lock field, 1 to 5 the bank
  task automatic wr(input int r, input logic [7:0] v);
    host.xfer({1'b0, 6'(mdc_pkg::ADDR_LOCK + r), 1'b0, v}, 16);
  endtask
  task automatic rd(input int r, input logic [7:0] e);
    expq.push_back(e);
    host.xfer({1'b1, 6'(mdc_pkg::ADDR_LOCK + r), 9'h000}, 16);
  endtask
  task automatic rst();
    ARST_N = 1'b0;
    cyc(5);
    ARST_N = 1'b1;
    cyc(6);
  endtask
  task automatic rst_chk();
    for (int j = 0; j < 5; j++)
      rd(j + 1, RV[j]);
    `CHK("cfg", cfg_of(RV[0], RV[1], RV[2], RV[3], RV[4]), CFG)
    `CHK("hiz", 1'b0, DRIVER_HIZ)
  endtask
  task automatic oc_pulse(input int n);
    OC_RAW = 1'b1;
    cyc(n);
    OC_RAW = 1'b0;
    cyc(4);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    ARST_N = 1'b0;
    CE = 1'b1;
    OC_RAW = 1'b0;
    OTW_RAW = 1'b0;
    PWM_IN = 1'b0;
    void'($urandom(77191));
    @(negedge CLK);
    rst();
    rst_chk();
    $display("test reset values done");
    // Random contents; first passes walk every two-bit code
    for (int i = 0; i < 8; i++)
    begin
      foreach (d[j]) d[j] = 8'($urandom);
      if (i < 4)
      begin
        d[0][4:3] = 2'(i);
        d[0][2:1] = 2'(i);
        d[2][5:4] = 2'(i);
        d[2][1:0] = 2'(i);
        d[3][1:0] = 2'(i);
        d[4][2:1] = 2'(i);
      end
      foreach (d[j]) wr(j + 1, d[j]);
      `CHK("cfg", cfg_of(d[0], d[1], d[2], d[3], d[4]), CFG)
      `CHK("hiz", d[2][7], DRIVER_HIZ)
      foreach (d[j]) rd(j + 1, d[j] & MSK[j]);
    end
    $display("test write read done");
    rst();
    rst_chk();
    $display("test second reset done");
    // Wrong key leaves bank open, lock key shuts it, unlock reopens
    wr(0, 8'h05);
    wr(3, 8'h07);
    rd(3, 8'h07);
    wr(0, 8'h06);
    wr(3, 8'h80);
    rd(3, 8'h07);
    rd(0, 8'h06);
    `CHK("hiz", 1'b0, DRIVER_HIZ)
    wr(0, 8'h03);
    wr(3, 8'h80);
    rd(3, 8'h80);
    `CHK("hiz", 1'b1, DRIVER_HIZ)
    // Clock enable low freezes the synchronisers, so a whole frame is lost
    CE = 1'b0;
    wr(3, 8'h00);
    CE = 1'b1;
    rd(3, 8'h80);
    `CHK("hiz", 1'b1, DRIVER_HIZ)
    wr(6, 8'hff);
    rd(6, 8'h00);
    rd(60, 8'h00);
    $display("test lock done");
    // Short frame is a serial fault; pin reporting follows the bits
    wr(3, 8'h00);
    wr(2, 8'h44);
    host.xfer(16'h0000, 12);
    cyc(4);
    `CHK("fault pin", 1'b1, FAULT_N_OE)
    wr(1, 8'h61);
    `CHK("fault pin", 1'b0, FAULT_N_OE)
    rd(1, 8'h60);
    wr(2, 8'h46);
    host.xfer(16'h0000, 12);
    cyc(4);
    `CHK("fault pin", 1'b0, FAULT_N_OE)
    OTW_RAW = 1'b1;
    cyc(8);
    `CHK("fault pin", 1'b0, FAULT_N_OE)
    wr(2, 8'h47);
    `CHK("fault pin", 1'b1, FAULT_N_OE)
    OTW_RAW = 1'b0;
    wr(1, 8'h61);
    `CHK("fault pin", 1'b0, FAULT_N_OE)
    $display("test fault pin done");
    // Every response code, long and short retry wait
    for (int k = 0; k < 5; k++)
    begin
      wr(3, OCV[k]);
      oc_pulse(3);
      `CHK("oc glitch", 1'b0, OC_ACTIVE)
      oc_pulse(12);
      `CHK("oc state", OCV[k][1:0] < 2, OC_ACTIVE)
      `CHK("oc pin", OCV[k][1:0] != 3, FAULT_N_OE)
      PWM_IN = ~PWM_IN;
      cyc(30);
      `CHK("oc retry", OCV[k] == 8'h08 || OCV[k] == 8'h09, OC_ACTIVE)
      cyc(60);
      `CHK("oc retry", OCV[k] == 8'h08, OC_ACTIVE)
      wr(1, 8'h61);
      `CHK("oc clear", 1'b0, OC_ACTIVE | FAULT_N_OE)
    end
    wr(3, 8'h40);
    oc_pulse(12);
    `CHK("oc latch", 1'b1, OC_ACTIVE)
    PWM_IN = ~PWM_IN;
    cyc(8);
    `CHK("oc cycle clear", 1'b0, OC_ACTIVE)
    `CHK("oc pin", 1'b1, FAULT_N_OE)
    $display("test overcurrent done");
    if (expq.size() != 0)
    begin
      $display("[FAIL] read notes left exp 0 got %0d", expq.size());
      fail_count++;
    end
    results();
  end
endmodule
`default_nettype wire
